// ===== common/gyrs_cfg.svh
`ifndef GYRS_CFG_SVH
`define GYRS_CFG_SVH

// register offsets
`define GYRS_RO_LAST 6'h0E
`define GYRS_SOFT_RESET_ADDR 6'h14
`define GYRS_LATCH_CTRL_ADDR 6'h21
`define GYRS_HI_RATE_CFG_Y 6'h24
`define GYRS_HI_RATE_HOLD_Y 6'h25
`define GYRS_HI_RATE_CFG_Z 6'h26
`define GYRS_HI_RATE_HOLD_Z 6'h27
`define GYRS_RSVD_28 6'h28
`define GYRS_RSVD_29 6'h29
`define GYRS_RSVD_2A 6'h2A
`define GYRS_RSVD_2B 6'h2B
`define GYRS_RSVD_2D 6'h2D
`define GYRS_RSVD_2E 6'h2E
`define GYRS_RSVD_2F 6'h2F
`define GYRS_RSVD_30 6'h30
`define GYRS_SLOW_COMP_CFG 6'h31
`define GYRS_FAST_COMP_CFG 6'h32
`define GYRS_NONVOLATILE_CTRL 6'h33
`define GYRS_HOST_PORT_CFG 6'h34
`define GYRS_RSVD_35 6'h35
`define GYRS_COMP_LOW_BITS 6'h36
`define GYRS_COMP_X_HIGH 6'h37
`define GYRS_COMP_Y_HIGH 6'h38
`define GYRS_COMP_Z_HIGH 6'h39
`define GYRS_SCRATCH_LOW 6'h3A
`define GYRS_SCRATCH_HIGH 6'h3B
`define GYRS_SELF_TEST_STATUS 6'h3C
`define GYRS_QUEUE_LEVEL_CFG 6'h3D
`define GYRS_QUEUE_MODE_CFG 6'h3E
`define GYRS_QUEUE_READ_PORT 6'h3F

// reset values
`define GYRS_RST_HI_RATE_CFG 8'h02
`define GYRS_RST_HI_RATE_HOLD 8'h19
`define GYRS_RST_RSVD_28 8'h24
`define GYRS_RST_RSVD_29 8'h19
`define GYRS_RST_RSVD_2A 8'hE8
`define GYRS_RST_RSVD_2B 8'h42
`define GYRS_RST_RSVD_2D 8'h40
`define GYRS_RST_RSVD_2E 8'h81
`define GYRS_RST_RSVD_2F 8'hE0
`define GYRS_RST_RSVD_30 8'hE8
`define GYRS_RST_RSVD_35 8'h00
`define GYRS_RST_SLOW_COMP 8'h60
`define GYRS_RST_FAST_COMP 8'hC0
`define GYRS_RST_ZERO 8'h00
`define GYRS_RST_UNLISTED 8'h00

// field positions and masks
`define GYRS_LATCH_RESET_INT_BIT 7
`define GYRS_HOST_PORT_MASK 8'h3F
`define GYRS_QUEUE_MODE_MASK 8'hC3
`define GYRS_NVM_WRITABLE_MASK 8'h0B
`define GYRS_NVM_READY_BIT 2
`define GYRS_ST_TRIG_BIT 0
`define GYRS_ST_READY_BIT 1
`define GYRS_ST_FAIL_BIT 2
`define GYRS_ST_RATE_OK_BIT 4

// timing counts
`define GYRS_SOFT_RESET_CODE 8'hB6
`define GYRS_SOFT_RESET_NS 100
`define GYRS_SOFT_RESET_CYC ((`GYRS_SOFT_RESET_NS + 3) / 4)

`endif

// ===== common/gyrs_pkg.sv
package gyrs_pkg;

   // one host register access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } gyrs_req_type;

   // soft reset sequencer states
   typedef enum logic [1:0] {
      GYRS_SR_IDLE = 2'b00,
      GYRS_SR_BUSY = 2'b01,
      GYRS_SR_DONE = 2'b10
   } gyrs_sr_state_type;

endpackage

// ===== verilog/gyrs_cfg_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "gyrs_cfg.svh"

// one writable byte with its own default and writable-bit mask
module gyrs_cfg_reg #(
   parameter logic [5:0] ADDR = 6'h00,
   parameter logic [7:0] RST = 8'h00,
   parameter logic [7:0] MASK = 8'hFF
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic soft_rst_in,
   // write port
   input wire logic wr_in,
   input wire logic [5:0] addr_in,
   input wire logic [7:0] wdata_in,
   // contents
   output logic [7:0] value_out
);
   logic [7:0] value_q;

   // masked bits keep their state, so reserved writes are dropped
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         value_q <= RST;
      end else if (soft_rst_in) begin
         value_q <= RST;
      end else if (wr_in && addr_in == ADDR) begin
         value_q <= (wdata_in & MASK) | (value_q & ~MASK);
      end
   end

   assign value_out = value_q;
endmodule
`default_nettype wire

// ===== verilog/gyrs_soft_reset.sv
`timescale 1ns/1ps
`default_nettype none
`include "gyrs_cfg.svh"

// soft reset launcher: a write of the reset code starts a timed sequence
module gyrs_soft_reset (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // launch
   input wire logic launch_in,
   // status
   output logic reset_out,
   output logic busy_out
);
   localparam int CYC = (`GYRS_SOFT_RESET_CYC < 1) ? 1 : `GYRS_SOFT_RESET_CYC;
   gyrs_pkg::gyrs_sr_state_type state_q;
   logic [7:0] cnt_q;

   // hold internal reset for a fixed count, then release
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= gyrs_pkg::GYRS_SR_IDLE;
         cnt_q <= 8'h00;
      end else begin
         case (state_q)
            gyrs_pkg::GYRS_SR_IDLE: begin
               if (launch_in) begin
                  state_q <= gyrs_pkg::GYRS_SR_BUSY;
                  cnt_q <= 8'(CYC - 1);
               end
            end
            gyrs_pkg::GYRS_SR_BUSY: begin
               if (cnt_q == 8'h00) begin
                  state_q <= gyrs_pkg::GYRS_SR_DONE;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            gyrs_pkg::GYRS_SR_DONE: begin
               state_q <= gyrs_pkg::GYRS_SR_IDLE;
            end
            default: begin
               state_q <= gyrs_pkg::GYRS_SR_IDLE;
            end
         endcase
      end
   end

   assign reset_out = (state_q == gyrs_pkg::GYRS_SR_BUSY);
   assign busy_out = (state_q != gyrs_pkg::GYRS_SR_IDLE);
endmodule
`default_nettype wire

// ===== verilog/gyrs_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "gyrs_cfg.svh"

// Summary of operation
// [R01] every register is one byte; host only reads and writes registers
// [R02] one decoded space of 64 byte addresses, 0x00 to queue_read_port
// [R03] writes to reserved bits leave state and behaviour unchanged
// [R04] reserved bits read with no guaranteed value; here partly reserved registers read them as zero, fully reserved addresses read their defaults
// [R05] host should leave fully reserved addresses alone
// [R06] host should mask reserved bits of partly reserved registers
// [R07] addresses 0x00 to 0x0E are read-only; writes are dropped
// [R08] interrupt-reset bit and soft-reset register launch internal sequences
// [R09] sequence-launching bits are write-only and read back zero
// [R10] after power-on or soft reset, listed defaults hold until written
module gyrs_regs (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // host register access
   input wire gyrs_pkg::gyrs_req_type req_in,
   output logic [7:0] rdata_out,
   output logic rvalid_out,
   // status from the sensing core
   input wire logic [7:0] lower_rdata_in,
   input wire logic [7:0] queue_data_in,
   input wire logic st_ready_in,
   input wire logic st_fail_in,
   input wire logic rate_ok_in,
   input wire logic nvm_ready_in,
   // configuration to the sensing core
   output logic [7:0] hi_rate_cfg_y_out,
   output logic [7:0] hi_rate_hold_y_out,
   output logic [7:0] hi_rate_cfg_z_out,
   output logic [7:0] hi_rate_hold_z_out,
   output logic [7:0] slow_comp_cfg_out,
   output logic [7:0] fast_comp_cfg_out,
   output logic [7:0] host_port_cfg_out,
   output logic [7:0] queue_level_cfg_out,
   output logic [7:0] queue_mode_cfg_out,
   output logic [35:0] comp_value_out,
   output logic [11:0] scratch_value_out,
   // sequence launches
   output logic int_reset_out,
   output logic nvm_prog_out,
   output logic st_start_out,
   output logic queue_pop_out,
   output logic soft_reset_out
);
   logic wr_ok;
   logic soft_rst;
   logic sr_busy;
   logic sr_launch;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic int_reset_q;
   logic nvm_prog_q;
   logic st_start_q;
   logic queue_pop_q;
   logic [7:0] nvm_ctrl_q;
   logic [7:0] comp_low_q;
   logic [7:0] comp_x_q;
   logic [7:0] comp_y_q;
   logic [7:0] comp_z_q;
   logic [7:0] scr_low_q;
   logic [7:0] scr_high_q;
   logic [7:0] rsvd_val [0:8];

   // read-only window refuses writes; soft reset sequence also blocks them
   assign wr_ok = req_in.wr && (req_in.addr > `GYRS_RO_LAST) && !sr_busy; // [R07]

   // soft reset launches only on the documented code, never stored
   assign sr_launch = wr_ok && req_in.addr == `GYRS_SOFT_RESET_ADDR
                      && req_in.wdata == `GYRS_SOFT_RESET_CODE; // [R08]

   gyrs_soft_reset u_soft_reset (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .launch_in(sr_launch),
      .reset_out(soft_rst),
      .busy_out(sr_busy)
   );

   // plain configuration registers, each with its listed default
   gyrs_cfg_reg #(.ADDR(`GYRS_HI_RATE_CFG_Y), .RST(`GYRS_RST_HI_RATE_CFG), .MASK(8'hFF)) u_cfg_y (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .soft_rst_in(soft_rst), // [R10]
      .wr_in(wr_ok), .addr_in(req_in.addr), .wdata_in(req_in.wdata),
      .value_out(hi_rate_cfg_y_out)
   );
   gyrs_cfg_reg #(.ADDR(`GYRS_HI_RATE_HOLD_Y), .RST(`GYRS_RST_HI_RATE_HOLD), .MASK(8'hFF)) u_hold_y (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .soft_rst_in(soft_rst),
      .wr_in(wr_ok), .addr_in(req_in.addr), .wdata_in(req_in.wdata),
      .value_out(hi_rate_hold_y_out)
   );
   gyrs_cfg_reg #(.ADDR(`GYRS_HI_RATE_CFG_Z), .RST(`GYRS_RST_HI_RATE_CFG), .MASK(8'hFF)) u_cfg_z (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .soft_rst_in(soft_rst),
      .wr_in(wr_ok), .addr_in(req_in.addr), .wdata_in(req_in.wdata),
      .value_out(hi_rate_cfg_z_out)
   );
   gyrs_cfg_reg #(.ADDR(`GYRS_HI_RATE_HOLD_Z), .RST(`GYRS_RST_HI_RATE_HOLD), .MASK(8'hFF)) u_hold_z (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .soft_rst_in(soft_rst),
      .wr_in(wr_ok), .addr_in(req_in.addr), .wdata_in(req_in.wdata),
      .value_out(hi_rate_hold_z_out)
   );
   gyrs_cfg_reg #(.ADDR(`GYRS_SLOW_COMP_CFG), .RST(`GYRS_RST_SLOW_COMP), .MASK(8'hFF)) u_slow (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .soft_rst_in(soft_rst),
      .wr_in(wr_ok), .addr_in(req_in.addr), .wdata_in(req_in.wdata),
      .value_out(slow_comp_cfg_out)
   );
   gyrs_cfg_reg #(.ADDR(`GYRS_FAST_COMP_CFG), .RST(`GYRS_RST_FAST_COMP), .MASK(8'hFF)) u_fast (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .soft_rst_in(soft_rst),
      .wr_in(wr_ok), .addr_in(req_in.addr), .wdata_in(req_in.wdata),
      .value_out(fast_comp_cfg_out)
   );
   gyrs_cfg_reg #(.ADDR(`GYRS_HOST_PORT_CFG), .RST(`GYRS_RST_ZERO),
                  .MASK(`GYRS_HOST_PORT_MASK)) u_port (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .soft_rst_in(soft_rst), // [R03]
      .wr_in(wr_ok), .addr_in(req_in.addr), .wdata_in(req_in.wdata),
      .value_out(host_port_cfg_out)
   );
   gyrs_cfg_reg #(.ADDR(`GYRS_QUEUE_LEVEL_CFG), .RST(`GYRS_RST_ZERO), .MASK(8'hFF)) u_qlvl (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .soft_rst_in(soft_rst),
      .wr_in(wr_ok), .addr_in(req_in.addr), .wdata_in(req_in.wdata),
      .value_out(queue_level_cfg_out)
   );
   gyrs_cfg_reg #(.ADDR(`GYRS_QUEUE_MODE_CFG), .RST(`GYRS_RST_ZERO),
                  .MASK(`GYRS_QUEUE_MODE_MASK)) u_qmode (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .soft_rst_in(soft_rst), // [R03]
      .wr_in(wr_ok), .addr_in(req_in.addr), .wdata_in(req_in.wdata),
      .value_out(queue_mode_cfg_out)
   );

   // fully reserved bytes keep their defaults; writes never land
   assign rsvd_val[0] = `GYRS_RST_RSVD_28; // [R03]
   assign rsvd_val[1] = `GYRS_RST_RSVD_29;
   assign rsvd_val[2] = `GYRS_RST_RSVD_2A;
   assign rsvd_val[3] = `GYRS_RST_RSVD_2B;
   assign rsvd_val[4] = `GYRS_RST_RSVD_2D;
   assign rsvd_val[5] = `GYRS_RST_RSVD_2E;
   assign rsvd_val[6] = `GYRS_RST_RSVD_2F;
   assign rsvd_val[7] = `GYRS_RST_RSVD_30;
   assign rsvd_val[8] = `GYRS_RST_RSVD_35;

   // nonvolatile control: the program trigger bit is a one-shot
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         nvm_ctrl_q <= `GYRS_RST_ZERO;
         nvm_prog_q <= 1'b0;
      end else if (soft_rst) begin
         nvm_ctrl_q <= `GYRS_RST_ZERO; // [R10]
         nvm_prog_q <= 1'b0;
      end else begin
         nvm_prog_q <= wr_ok && req_in.addr == `GYRS_NONVOLATILE_CTRL
                       && req_in.wdata[1]; // [R08]
         if (wr_ok && req_in.addr == `GYRS_NONVOLATILE_CTRL) begin
            nvm_ctrl_q <= req_in.wdata & `GYRS_NVM_WRITABLE_MASK & 8'hFD;
         end
      end
   end

   // compensation and scratch bytes have no listed default; cleared at power-on, kept through soft reset
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         comp_low_q <= `GYRS_RST_UNLISTED;
         comp_x_q <= `GYRS_RST_UNLISTED;
         comp_y_q <= `GYRS_RST_UNLISTED;
         comp_z_q <= `GYRS_RST_UNLISTED;
         scr_low_q <= `GYRS_RST_UNLISTED;
         scr_high_q <= `GYRS_RST_UNLISTED;
      end else if (wr_ok) begin
         case (req_in.addr)
            `GYRS_COMP_LOW_BITS: comp_low_q <= req_in.wdata;
            `GYRS_COMP_X_HIGH: comp_x_q <= req_in.wdata;
            `GYRS_COMP_Y_HIGH: comp_y_q <= req_in.wdata;
            `GYRS_COMP_Z_HIGH: comp_z_q <= req_in.wdata;
            `GYRS_SCRATCH_LOW: scr_low_q <= req_in.wdata;
            `GYRS_SCRATCH_HIGH: scr_high_q <= req_in.wdata;
            default: begin
            end
         endcase
      end
   end

   // one-shot launches: interrupt reset, self-test start, queue pop
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         int_reset_q <= 1'b0;
         st_start_q <= 1'b0;
         queue_pop_q <= 1'b0;
      end else begin
         int_reset_q <= wr_ok && req_in.addr == `GYRS_LATCH_CTRL_ADDR
                        && req_in.wdata[`GYRS_LATCH_RESET_INT_BIT]; // [R08]
         st_start_q <= wr_ok && req_in.addr == `GYRS_SELF_TEST_STATUS
                       && req_in.wdata[`GYRS_ST_TRIG_BIT];
         queue_pop_q <= req_in.rd && !req_in.wr && !sr_busy
                        && req_in.addr == `GYRS_QUEUE_READ_PORT;
      end
   end

   // read mux; launch bits and unused reserved bits read as zero
   always_comb begin
      rdata_d = 8'h00;
      if (req_in.addr <= `GYRS_RO_LAST) begin
         rdata_d = lower_rdata_in; // [R02]
      end else begin
         case (req_in.addr)
            `GYRS_SOFT_RESET_ADDR: rdata_d = 8'h00; // [R09]
            `GYRS_HI_RATE_CFG_Y: rdata_d = hi_rate_cfg_y_out;
            `GYRS_HI_RATE_HOLD_Y: rdata_d = hi_rate_hold_y_out;
            `GYRS_HI_RATE_CFG_Z: rdata_d = hi_rate_cfg_z_out;
            `GYRS_HI_RATE_HOLD_Z: rdata_d = hi_rate_hold_z_out;
            `GYRS_RSVD_28: rdata_d = rsvd_val[0];
            `GYRS_RSVD_29: rdata_d = rsvd_val[1];
            `GYRS_RSVD_2A: rdata_d = rsvd_val[2];
            `GYRS_RSVD_2B: rdata_d = rsvd_val[3];
            `GYRS_RSVD_2D: rdata_d = rsvd_val[4];
            `GYRS_RSVD_2E: rdata_d = rsvd_val[5];
            `GYRS_RSVD_2F: rdata_d = rsvd_val[6];
            `GYRS_RSVD_30: rdata_d = rsvd_val[7];
            `GYRS_SLOW_COMP_CFG: rdata_d = slow_comp_cfg_out;
            `GYRS_FAST_COMP_CFG: rdata_d = fast_comp_cfg_out;
            `GYRS_NONVOLATILE_CTRL: begin
               rdata_d = nvm_ctrl_q; // [R09]
               rdata_d[`GYRS_NVM_READY_BIT] = nvm_ready_in;
            end
            `GYRS_HOST_PORT_CFG: rdata_d = host_port_cfg_out; // [R04]
            `GYRS_RSVD_35: rdata_d = rsvd_val[8];
            `GYRS_COMP_LOW_BITS: rdata_d = comp_low_q;
            `GYRS_COMP_X_HIGH: rdata_d = comp_x_q;
            `GYRS_COMP_Y_HIGH: rdata_d = comp_y_q;
            `GYRS_COMP_Z_HIGH: rdata_d = comp_z_q;
            `GYRS_SCRATCH_LOW: rdata_d = scr_low_q;
            `GYRS_SCRATCH_HIGH: rdata_d = scr_high_q;
            `GYRS_SELF_TEST_STATUS: begin
               rdata_d[`GYRS_ST_READY_BIT] = st_ready_in; // [R09]
               rdata_d[`GYRS_ST_FAIL_BIT] = st_fail_in;
               rdata_d[`GYRS_ST_RATE_OK_BIT] = rate_ok_in;
            end
            `GYRS_QUEUE_LEVEL_CFG: rdata_d = queue_level_cfg_out;
            `GYRS_QUEUE_MODE_CFG: rdata_d = queue_mode_cfg_out;
            `GYRS_QUEUE_READ_PORT: rdata_d = queue_data_in;
            default: rdata_d = 8'h00; // [R01]
         endcase
      end
   end

   // registered read answer, one cycle after the request
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= req_in.rd && !req_in.wr;
         if (req_in.rd && !req_in.wr) begin
            rdata_q <= rdata_d;
         end
      end
   end

   // offsets: 12 bits per axis, low bits packed in the shared comp_low_q and scr_low_q bytes
   assign comp_value_out = {comp_x_q, comp_low_q[7:6], scr_low_q[3:2],
                            comp_y_q, comp_low_q[5:3], scr_low_q[1],
                            comp_z_q, comp_low_q[2:0], scr_low_q[0]};
   assign scratch_value_out = {scr_high_q, scr_low_q[7:4]};
   assign rdata_out = rdata_q;
   assign rvalid_out = rvalid_q;
   assign int_reset_out = int_reset_q;
   assign nvm_prog_out = nvm_prog_q;
   assign st_start_out = st_start_q;
   assign queue_pop_out = queue_pop_q;
   assign soft_reset_out = soft_rst;
endmodule
`default_nettype wire

// ===== tb/gyrs_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module gyrs_regs_checker (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // host access
   input wire gyrs_pkg::gyrs_req_type req_in,
   input wire logic rvalid_out,
   // register contents
   input wire logic [7:0] hi_rate_cfg_y_out,
   input wire logic [7:0] slow_comp_cfg_out,
   input wire logic [7:0] fast_comp_cfg_out,
   input wire logic [7:0] host_port_cfg_out,
   input wire logic [7:0] queue_mode_cfg_out,
   // sequence launches
   input wire logic int_reset_out,
   input wire logic queue_pop_out,
   input wire logic soft_reset_out
);
   logic sr_prev_q;
   logic [5:0] sr_cnt_q;
   logic [7:0] wdata_q;
   logic quiet;
   logic rd_only;
   // writes land only outside the soft reset window and the DONE cycle after it
   assign quiet = !soft_reset_out && !sr_prev_q;
   assign rd_only = req_in.rd && !req_in.wr;
   // soft reset length and last write data
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sr_prev_q <= 1'b0;
         sr_cnt_q <= 6'h00;
         wdata_q <= 8'h00;
      end else begin
         sr_prev_q <= soft_reset_out;
         sr_cnt_q <= soft_reset_out ? sr_cnt_q + 6'h01 : 6'h00;
         wdata_q <= req_in.wdata;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   a_read_answer: assert property (rd_only |=> rvalid_out)
      else $error("read request not answered");
   a_no_stray_valid: assert property (!rd_only |=> !rvalid_out)
      else $error("read valid without a read");
   a_write_visible: assert property (req_in.wr && req_in.addr == 6'h24 && quiet
      |=> hi_rate_cfg_y_out == wdata_q)
      else $error("write to hi_rate_cfg_y not visible");
   a_port_rsvd_bits: assert property (req_in.wr && req_in.addr == 6'h34 && quiet
      |=> host_port_cfg_out == (wdata_q & 8'h3F))
      else $error("reserved bits of host_port_cfg took a write");
   a_mode_rsvd_bits: assert property (req_in.wr && req_in.addr == 6'h3E && quiet
      |=> queue_mode_cfg_out == (wdata_q & 8'hC3))
      else $error("reserved bits of queue_mode_cfg took a write");
   a_int_reset_pulse: assert property (req_in.wr && req_in.addr == 6'h21 && req_in.wdata[7]
      && quiet |=> int_reset_out
      ##1 (!int_reset_out || $past(req_in.wr && req_in.addr == 6'h21 && req_in.wdata[7])))
      else $error("interrupt reset pulse wrong");
   a_sr_launch: assert property (req_in.wr && req_in.addr == 6'h14
      && req_in.wdata == 8'hB6 && quiet |=> soft_reset_out)
      else $error("soft reset not launched");
   a_sr_length: assert property ($fell(soft_reset_out) |-> sr_cnt_q == 6'd25)
      else $error("soft reset length wrong");
   a_sr_defaults: assert property ($fell(soft_reset_out) |-> hi_rate_cfg_y_out == 8'h02
      && slow_comp_cfg_out == 8'h60 && fast_comp_cfg_out == 8'hC0)
      else $error("defaults not restored by soft reset");
   a_pop_on_read: assert property (rd_only && req_in.addr == 6'h3F && quiet
      |=> queue_pop_out)
      else $error("queue read did not pop");
endmodule
`default_nettype wire

// ===== tb/gyrs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module gyrs_core_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // sequence launches
   input wire logic st_start_in,
   input wire logic queue_pop_in,
   // status to the register file
   output logic [7:0] lower_rdata_out,
   output logic [7:0] queue_data_out,
   output logic st_ready_out,
   output logic nvm_ready_out
);
   // lower map stands in as one fixed byte
   assign lower_rdata_out = 8'h5A;
   assign nvm_ready_out = 1'b1;
   // queue moves on one byte per pop, so a missed pop shows up
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         queue_data_out <= 8'hA0;
      end else if (queue_pop_in) begin
         queue_data_out <= queue_data_out + 8'h01;
      end
   end
   // self test finishes right after launch
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_ready_out <= 1'b0;
      end else if (st_start_in) begin
         st_ready_out <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== tb/test_gyrs_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_gyrs_regs;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   gyrs_pkg::gyrs_req_type req = '0;
   logic [7:0] rdata, lower, qdata;
   logic rvalid, st_ready, nvm_ready, int_rst, nvm_prog, st_start, pop, soft_rst;
   logic st_fail = 1'b0;
   logic rate_ok = 1'b1;
   logic [35:0] comp;
   logic [11:0] scratch;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;
   // address in the upper six bits, default in the low byte
   logic [13:0] tbl [0:19] = '{14'h2402, 14'h2519, 14'h2602, 14'h2719, 14'h2824, 14'h2919,
      14'h2AE8, 14'h2B42, 14'h2D40, 14'h2E81, 14'h2FE0, 14'h30E8, 14'h3160, 14'h32C0,
      14'h3304, 14'h3400, 14'h3500, 14'h3D00, 14'h3E00, 14'h3FA0};
   logic [5:0] rw_addr [0:6] = '{6'h24, 6'h25, 6'h26, 6'h27, 6'h31, 6'h32, 6'h3D};

   always #2 clk_in = ~clk_in;

   gyrs_regs DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .rdata_out(rdata),
      .rvalid_out(rvalid), .lower_rdata_in(lower), .queue_data_in(qdata),
      .st_ready_in(st_ready), .st_fail_in(st_fail), .rate_ok_in(rate_ok),
      .nvm_ready_in(nvm_ready), .hi_rate_cfg_y_out(), .hi_rate_hold_y_out(),
      .hi_rate_cfg_z_out(), .hi_rate_hold_z_out(), .slow_comp_cfg_out(),
      .fast_comp_cfg_out(), .host_port_cfg_out(), .queue_level_cfg_out(),
      .queue_mode_cfg_out(), .comp_value_out(comp), .scratch_value_out(scratch),
      .int_reset_out(int_rst), .nvm_prog_out(nvm_prog), .st_start_out(st_start),
      .queue_pop_out(pop), .soft_reset_out(soft_rst));

   gyrs_core_model u_core (.clk_in(clk_in), .rst_n_in(rst_n_in), .st_start_in(st_start),
      .queue_pop_in(pop), .lower_rdata_out(lower), .queue_data_out(qdata),
      .st_ready_out(st_ready), .nvm_ready_out(nvm_ready));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_in);
      req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clk_in);
      req <= '0;
   endtask

   // reads answer one cycle after the request is taken
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp, input logic [7:0] m);
      @(posedge clk_in);
      req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clk_in);
      req <= '0;
      @(negedge clk_in);
      chk({35'h0, rvalid}, 36'h1);
      chk({28'h0, rdata & m}, {28'h0, exp & m});
   endtask

   // hang guard, far above the expected run length
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         end_sim();
      end
   end

   initial begin
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      for (int i = 0; i < 20; i++) rd_chk(tbl[i][13:8], tbl[i][7:0], 8'hFF);
      rd_chk(6'h3F, 8'hA1, 8'hFF);
      for (int i = 0; i < 7; i++) begin
         wr_reg(rw_addr[i], 8'hA5);
         wr_reg(rw_addr[i], 8'h5A);
         rd_chk(rw_addr[i], 8'h5A, 8'hFF);
      end
      wr_reg(6'h05, 8'hFF);
      rd_chk(6'h05, 8'h5A, 8'hFF);
      rd_chk(6'h0E, 8'h5A, 8'hFF);
      wr_reg(6'h28, 8'h00);
      rd_chk(6'h28, 8'h24, 8'hFF);
      wr_reg(6'h34, 8'hFF);
      rd_chk(6'h34, 8'h3F, 8'hFF);
      wr_reg(6'h3E, 8'hFF);
      rd_chk(6'h3E, 8'hC3, 8'hFF);
      wr_reg(6'h21, 8'h80);
      @(negedge clk_in);
      chk({35'h0, int_rst}, 36'h1);
      @(negedge clk_in);
      chk({35'h0, int_rst}, 36'h0);
      rd_chk(6'h21, 8'h00, 8'h80);
      wr_reg(6'h33, 8'h0B);
      @(negedge clk_in);
      chk({35'h0, nvm_prog}, 36'h1);
      rd_chk(6'h33, 8'h0D, 8'hFF);
      wr_reg(6'h3C, 8'h01);
      @(negedge clk_in);
      chk({35'h0, st_start}, 36'h1);
      rd_chk(6'h3C, 8'h12, 8'h17);
      // offset and scratch bytes spread over shared registers
      wr_reg(6'h37, 8'hAB);
      wr_reg(6'h38, 8'h12);
      wr_reg(6'h39, 8'h34);
      wr_reg(6'h36, 8'hC5);
      wr_reg(6'h3A, 8'h9E);
      wr_reg(6'h3B, 8'h7C);
      @(negedge clk_in);
      chk(comp, 36'hABF12134A);
      chk({24'h0, scratch}, 36'h7C9);
      // soft reset: a write inside the window must be lost
      wr_reg(6'h24, 8'h55);
      wr_reg(6'h14, 8'hB6);
      wr_reg(6'h24, 8'h77);
      n = 0;
      @(negedge clk_in);
      while (soft_rst === 1'b1 && n < 40) begin
         n++;
         @(negedge clk_in);
      end
      chk(36'(n), 36'd23);
      rd_chk(6'h24, 8'h02, 8'hFF);
      rd_chk(6'h14, 8'h00, 8'hFF);
      chk(comp, 36'hABF12134A);
      end_sim();
   end
endmodule

bind gyrs_regs gyrs_regs_checker u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .req_in(req_in), .rvalid_out(rvalid_out), .hi_rate_cfg_y_out(hi_rate_cfg_y_out),
   .slow_comp_cfg_out(slow_comp_cfg_out), .fast_comp_cfg_out(fast_comp_cfg_out),
   .host_port_cfg_out(host_port_cfg_out), .queue_mode_cfg_out(queue_mode_cfg_out),
   .int_reset_out(int_reset_out), .queue_pop_out(queue_pop_out),
   .soft_reset_out(soft_reset_out));
`default_nettype wire
